// file: design/bmx_regs_map.svh
/*
 * Register map constants for the bus multiplexer status and control bank:
 * offsets, bit positions, reset values and synchroniser depth.
 * Assumes inclusion by bare name from design files under design/.
 */
`ifndef BMX_REGS_MAP_SVH
`define BMX_REGS_MAP_SVH

`define BMX_OFS_STATUS      8'h00
`define BMX_OFS_CONTROL     8'h01

`define BMX_ST_CONN_BIT     7
`define BMX_ST_FAULT_HI     6
`define BMX_ST_FAULT_LO     3
`define BMX_ST_FAIL_BIT     2
`define BMX_ST_TOLATCH_BIT  1
`define BMX_ST_TOLIVE_BIT   0

`define BMX_CT_UPACC_BIT    7
`define BMX_CT_DNACC_BIT    6
`define BMX_CT_GP1_BIT      5
`define BMX_CT_GP2_BIT      4
`define BMX_CT_GP1LVL_BIT   1
`define BMX_CT_GP2LVL_BIT   0

`define BMX_CTRL_RESET      4'h3
`define BMX_SYNC_STAGES     3

`endif

// file: design/bmx_pkg.sv
/*
 * Types shared by the register bank and its testbench.
 * Assumes bmx_regs_map.svh sits beside it.
 */
package bmx_pkg;
    typedef logic [7:0] bmx_byte_t;
    typedef logic [3:0] bmx_fault_t;
    typedef logic [1:0] bmx_gpio_t;
endpackage

// file: design/bmx_sync.sv
/*
 * Three-stage synchroniser with agreement filter for a group of pins.
 * Assumes inputs are asynchronous to clk; rst_n is synchronous, active low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bmx_regs_map.svh"

module bmx_sync #(
    parameter int          WIDTH = 6,
    parameter logic [WIDTH-1:0] INIT = 6'h3F
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } bmx_sync_state_t;

    bmx_sync_state_t state_ff;
    bmx_sync_state_t nxt_state;

    // a level is accepted only once stages two and three agree
    always_comb begin
        nxt_state    = state_ff;
        nxt_state.s1 = pinIn;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (state_ff.s2[i] == state_ff.s3[i]) begin
                nxt_state.q[i] = state_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // every stage starts at the idle level so no false change follows reset
            state_ff <= {4{INIT}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pinOut = state_ff.q;
endmodule
`default_nettype wire

// file: design/bmx_regs.sv
/*
 * Status register 0 and control register 1 of a four-channel two-wire bus
 * multiplexer. The host write/read arrives as a decoded byte port from the
 * two-wire slave engine; fault, gpio pins and timeout/connection events
 * come from the surrounding device logic.
 */
// Overview of operation
// - status bit 7 reads 1 while any downstream bus is joined upstream.
// - status bits 6..3 show the four channel fault pins, uninverted.
// - status bit 2 reads 0 after a refused connection, else 1.
// - status bit 1 latches a stuck-bus timeout until fault clear.
// - status bit 0 shows the live stuck-low timeout state.
// - a write to offset 00h clears latched faults and stores nothing.
// - control bit 7 enables the upstream accelerator, default off.
// - control bit 6 enables the downstream accelerators, default off.
// - control bits 5 and 4 drive the two general outputs, default 1.
// - control bits 1 and 0 read the general pin levels; 3..2 read 0.
// - the fault output goes low on any fault pin low, stuck bus or, while enable is high, refusal.
// - enable low blocks access and resets registers to defaults.
`timescale 1ns/1ps
`default_nettype none
`include "bmx_regs_map.svh"

module bmx_regs (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              enable,
    input  wire logic              regWrStb,
    input  wire logic              regRdStb,
    input  wire logic [7:0]        regAddr,
    input  wire bmx_pkg::bmx_byte_t regWrData,
    output logic      [7:0]        regRdData,
    output logic                   regRdValid,
    input  wire logic              anyConnected,
    input  wire logic              connRefused,
    input  wire logic              stuckActive,
    input  wire bmx_pkg::bmx_fault_t channelFaultIn,
    input  wire bmx_pkg::bmx_gpio_t  generalPinIn,
    output logic                   upAccelEn,
    output logic                   downAccelEn,
    output logic                   generalPinOut1,
    output logic                   generalPinOut2,
    output logic                   faultOut_n
);
    import bmx_pkg::*;

    typedef struct packed {
        logic       enable;
        logic       failLatch;
        logic       toLatch;
        logic       upAcc;
        logic       dnAcc;
        logic       gp1;
        logic       gp2;
        bmx_byte_t  rdData;
        logic       rdValid;
        logic       fault_n;
    } bmx_regs_state_t;

    localparam bmx_regs_state_t RESET_STATE = '{
        enable:1'b0, failLatch:1'b0, toLatch:1'b0, upAcc:1'b0, dnAcc:1'b0,
        gp1:1'b1, gp2:1'b1, rdData:8'h00, rdValid:1'b0, fault_n:1'b1};

    bmx_regs_state_t state_ff;
    bmx_regs_state_t nxt_state;
    bmx_fault_t      faultSync;
    bmx_gpio_t       gpioSync;
    logic [5:0]      syncOut;
    bmx_byte_t       statusWord;
    bmx_byte_t       controlWord;
    logic            enableSync;
    logic            fClear;
    logic            ctrlWr;

    // pins from outside the clock domain, enable included
    bmx_sync #(
        .WIDTH (7),
        .INIT  (7'h7F)
    ) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  ({enable, channelFaultIn, generalPinIn}),
        .pinOut ({enableSync, faultSync, gpioSync})
    );
    assign syncOut = {faultSync, gpioSync};

    // host strobes count only while enable is high
    assign fClear = state_ff.enable && regWrStb && (regAddr == `BMX_OFS_STATUS);
    assign ctrlWr = state_ff.enable && regWrStb && (regAddr == `BMX_OFS_CONTROL);

    // status word assembly
    always_comb begin
        statusWord = 8'h00;
        statusWord[`BMX_ST_CONN_BIT] = anyConnected;
        statusWord[`BMX_ST_FAULT_HI:`BMX_ST_FAULT_LO] = {syncOut[2], syncOut[3],
                                                         syncOut[4], syncOut[5]};
        statusWord[`BMX_ST_FAIL_BIT] = ~state_ff.failLatch;
        statusWord[`BMX_ST_TOLATCH_BIT] = state_ff.toLatch;
        statusWord[`BMX_ST_TOLIVE_BIT] = stuckActive;
    end

    // control word readback, reserved bits 3..2 stay zero
    always_comb begin
        controlWord = 8'h00;
        controlWord[`BMX_CT_UPACC_BIT] = state_ff.upAcc;
        controlWord[`BMX_CT_DNACC_BIT] = state_ff.dnAcc;
        controlWord[`BMX_CT_GP1_BIT] = state_ff.gp1;
        controlWord[`BMX_CT_GP2_BIT] = state_ff.gp2;
        controlWord[`BMX_CT_GP1LVL_BIT] = gpioSync[1];
        controlWord[`BMX_CT_GP2LVL_BIT] = gpioSync[0];
    end

    // next-state logic; a new event wins over a clear in the same cycle
    always_comb begin
        nxt_state         = state_ff;
        nxt_state.enable  = enableSync;
        nxt_state.rdValid = 1'b0;
        if (fClear) begin
            nxt_state.failLatch = 1'b0;
            nxt_state.toLatch   = 1'b0;
        end
        if (connRefused) begin
            nxt_state.failLatch = 1'b1;
        end
        if (stuckActive) begin
            nxt_state.toLatch = 1'b1;
        end
        if (ctrlWr) begin
            nxt_state.upAcc = regWrData[`BMX_CT_UPACC_BIT];
            nxt_state.dnAcc = regWrData[`BMX_CT_DNACC_BIT];
            nxt_state.gp1   = regWrData[`BMX_CT_GP1_BIT];
            nxt_state.gp2   = regWrData[`BMX_CT_GP2_BIT];
        end
        if (state_ff.enable && regRdStb) begin
            nxt_state.rdValid = 1'b1;
            unique case (regAddr)
                `BMX_OFS_STATUS:  nxt_state.rdData = statusWord;
                `BMX_OFS_CONTROL: nxt_state.rdData = controlWord;
                default:          nxt_state.rdData = 8'h00;
            endcase
        end
        // any low fault pin, stuck bus or refusal pulls the alert low
        nxt_state.fault_n = ~(~(&faultSync) | stuckActive | nxt_state.failLatch);
        // enable low drops every register but the alert to its default; the alert still follows fault pins and stuck bus
        if (!enableSync) begin
            nxt_state         = RESET_STATE;
            nxt_state.fault_n = ~(~(&faultSync) | stuckActive);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= RESET_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign regRdData      = state_ff.rdData;
    assign regRdValid     = state_ff.rdValid;
    assign upAccelEn      = state_ff.upAcc;
    assign downAccelEn    = state_ff.dnAcc;
    assign generalPinOut1 = state_ff.gp1;
    assign generalPinOut2 = state_ff.gp2;
    assign faultOut_n     = state_ff.fault_n;

    // assertions
    property p_timeout_latch;
        @(posedge clk) disable iff (!rst_n)
        (stuckActive && enableSync) |=> state_ff.toLatch;
    endproperty
    a_timeout_latch: assert property (p_timeout_latch) else $error("timeout not latched");

    property p_latch_holds;
        @(posedge clk) disable iff (!rst_n)
        (state_ff.toLatch && !fClear && enableSync) |=> state_ff.toLatch;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latch lost");

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        (fClear && !stuckActive && !connRefused) |=> (!state_ff.toLatch && !state_ff.failLatch);
    endproperty
    a_clear: assert property (p_clear) else $error("fault clear failed");

    property p_clear_keeps_ctrl;
        @(posedge clk) disable iff (!rst_n)
        (fClear && enableSync) |=> $stable(controlWord[7:4]);
    endproperty
    a_clear_keeps_ctrl: assert property (p_clear_keeps_ctrl) else $error("ctrl changed");

    property p_ctrl_write;
        @(posedge clk) disable iff (!rst_n)
        (ctrlWr && enableSync) |=> (upAccelEn == $past(regWrData[7])
                                    && downAccelEn == $past(regWrData[6])
                                    && generalPinOut1 == $past(regWrData[5]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost");

    property p_disable_reset;
        @(posedge clk) disable iff (!rst_n)
        !enableSync |=> (!upAccelEn && !downAccelEn && generalPinOut1 && generalPinOut2);
    endproperty
    a_disable_reset: assert property (p_disable_reset) else $error("no default");

    property p_fault_out;
        @(posedge clk) disable iff (!rst_n)
        (faultSync != 4'hF) |=> !faultOut_n;
    endproperty
    a_fault_out: assert property (p_fault_out) else $error("alert not pulled");

    property p_status_read;
        @(posedge clk) disable iff (!rst_n)
        (state_ff.enable && regRdStb && regAddr == `BMX_OFS_STATUS && enableSync)
            |=> (regRdValid && regRdData[0] == $past(stuckActive)
                 && regRdData[7] == $past(anyConnected));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    c_clear: cover property (@(posedge clk) disable iff (!rst_n) fClear);
    c_ctrl: cover property (@(posedge clk) disable iff (!rst_n) ctrlWr);
    c_refuse: cover property (@(posedge clk) disable iff (!rst_n) connRefused ##1 !faultOut_n);
endmodule
`default_nettype wire

// file: test/bmx_host.sv
/*
 * Host side model: turns register accesses into strobes on the decoded
 * byte port. Assumes the register bank answers a read one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module bmx_host (
    input  wire logic       clk,
    output logic            wrStb,
    output logic            rdStb,
    output logic [7:0]      addr,
    output logic [7:0]      wrData,
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid
);
    // idle bus shows inverted leftovers so stale values never look valid
    initial begin
        wrStb = 1'b0;
        rdStb = 1'b0;
        addr = 8'hA5;
        wrData = 8'h5A;
    end

    // one-cycle write strobe; writing 00h only clears the latches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {wrStb, addr, wrData} = {1'b1, a, d};
        @(negedge clk);
        {wrStb, addr, wrData} = {1'b0, ~a, ~d};
    endtask

    // read strobe for one cycle; the answer stands in the cycle after the
    // strobe is taken, so it is looked at on the falling edge of that cycle
    // where it is settled; ok stays 0 when access is blocked
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge clk);
        {rdStb, addr} = {1'b1, a};
        @(negedge clk);
        {rdStb, addr} = {1'b0, ~a};
        if (rdValid === 1'b1) begin
            d = rdData;
            ok = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
/*
 * Self-checking bench for the status/control bank: a small model of the
 * two registers is compared with every read and every control output.
 * Assumes bmx_regs, bmx_sync and bmx_pkg are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import bmx_pkg::*;
    logic       clk = 0, rst_n = 0, enable = 1, anyConnected = 0;
    logic       connRefused = 0, stuckActive = 0, ok;
    bmx_fault_t channelFaultIn = 4'hF;
    bmx_gpio_t  generalPinIn = 2'h2;
    logic       wrStb, rdStb, rdValid, upAccelEn, downAccelEn, gpo1, gpo2, faultOut_n;
    logic [7:0] addr, rdData, got, wrData, wd;
    logic [3:0] ctrlM = 4'h3;
    logic       refM = 0, toM = 0;
    int         fails = 0, n_checks = 0;

    bmx_regs bmx_regs_inst (.clk(clk), .rst_n(rst_n), .enable(enable), .regWrStb(wrStb),
        .regRdStb(rdStb), .regAddr(addr), .regWrData(wrData), .regRdData(rdData),
        .regRdValid(rdValid), .anyConnected(anyConnected), .connRefused(connRefused),
        .stuckActive(stuckActive), .channelFaultIn(channelFaultIn),
        .generalPinIn(generalPinIn), .upAccelEn(upAccelEn), .downAccelEn(downAccelEn),
        .generalPinOut1(gpo1), .generalPinOut2(gpo2), .faultOut_n(faultOut_n));
    bmx_host bmx_host_inst (.clk(clk), .wrStb(wrStb), .rdStb(rdStb), .addr(addr),
        .wrData(wrData), .rdData(rdData), .rdValid(rdValid));

    initial forever #10 clk = ~clk;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // pins cross a synchroniser, so give them time before looking
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask

    // read both registers and the outputs, compare with the model
    task automatic check_all();
        bmx_host_inst.rd(8'h00, got, ok);
        chk("status", {anyConnected, channelFaultIn[0], channelFaultIn[1], channelFaultIn[2],
            channelFaultIn[3], ~refM, toM, stuckActive}, got);
        bmx_host_inst.rd(8'h01, got, ok);
        chk("control", {ctrlM, 2'h0, generalPinIn}, got);
        chk("outputs", {4'h0, ctrlM}, {4'h0, upAccelEn, downAccelEn, gpo1, gpo2});
        chk("fault out", {7'h0, &channelFaultIn & ~stuckActive & ~refM}, {7'h0, faultOut_n});
    endtask

    initial begin
        void'($urandom(27));
        repeat (2) @(negedge clk);
        rst_n = 1;
        settle();
        check_all();
        bmx_host_inst.rd(8'h05, got, ok);
        chk("unmapped", 8'h00, got);
        chk("unmapped valid", 8'h01, {7'h0, ok});
        // random pins and control writes, with a dummy status write mixed in
        repeat (20) begin
            @(negedge clk);
            {channelFaultIn, generalPinIn, anyConnected} = 7'($urandom);
            wd = 8'($urandom);
            bmx_host_inst.wr(8'h01, wd);
            ctrlM = wd[7:4];
            bmx_host_inst.wr(8'h00, 8'($urandom));
            settle();
            check_all();
        end
        // refused connection and stuck bus latch until a status write
        @(negedge clk);
        {connRefused, stuckActive, refM, toM} = 4'hF;
        @(negedge clk);
        connRefused = 0;
        settle();
        check_all();
        stuckActive = 0;
        settle();
        check_all();
        bmx_host_inst.wr(8'h00, 8'hFF);
        {refM, toM} = 2'h0;
        check_all();
        // enable low: defaults restored, latches dropped, accesses blocked
        @(negedge clk);
        connRefused = 1;
        @(negedge clk);
        connRefused = 0;
        enable = 0;
        settle();
        {ctrlM, refM} = {4'h3, 1'b0};
        bmx_host_inst.wr(8'h01, 8'hC0);
        bmx_host_inst.rd(8'h01, got, ok);
        chk("blocked read", 8'h00, {7'h0, ok});
        chk("disabled outputs", {4'h0, ctrlM}, {4'h0, upAccelEn, downAccelEn, gpo1, gpo2});
        enable = 1;
        settle();
        check_all();
        wrap_up();
    end

    // whole run is well under 3000 cycles
    initial begin
        #200us;
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
